// ### design/iss_consts.vh
// Constants for the instrument status summary block
`ifndef ISS_CONSTS_VH
`define ISS_CONSTS_VH

// Register widths
`define ISS_REG_W 16
`define ISS_SUB_W 2
`define ISS_SEL_W 4

// Register select codes on the command port
`define ISS_SEL_QUES_COND 4'h0
`define ISS_SEL_QUES_EVT 4'h1
`define ISS_SEL_QUES_ENA 4'h2
`define ISS_SEL_OPER_COND 4'h3
`define ISS_SEL_OPER_EVT 4'h4
`define ISS_SEL_OPER_ENA 4'h5
`define ISS_SEL_CLK_COND 4'h6
`define ISS_SEL_CLK_EVT 4'h7
`define ISS_SEL_CLK_ENA 4'h8
`define ISS_SEL_SYM_COND 4'h9
`define ISS_SEL_SYM_EVT 4'hA
`define ISS_SEL_SYM_ENA 4'hB
`define ISS_SEL_STB 4'hC

// Questionable register bit positions
`define ISS_Q_DATA_LOSS 0
`define ISS_Q_CLOCK_LOSS 5
`define ISS_Q_INPUT_GUARD 6
`define ISS_Q_DELAY_GUARD 7
`define ISS_Q_CAL_MISMATCH 8
`define ISS_Q_SYNC_LOSS 10
`define ISS_Q_SYMBOL 12
`define ISS_Q_MASK 16'h15E1

// Operation register bit positions
`define ISS_O_TEMP_HIGH 3
`define ISS_O_GATE_ON 4
`define ISS_O_GATE_ABORT 7
`define ISS_O_BIT_ERR 8
`define ISS_O_CENTERING 11
`define ISS_O_THR_ALIGN 12
`define ISS_O_AUTO_ALIGN 13
`define ISS_O_FAULT_CAPTURE 14
`define ISS_O_BLOCK_CHANGE 15
`define ISS_O_MASK 16'hF998

// Clock-loss and symbol-alignment sub-register bits
`define ISS_C_RECEIVER 0
`define ISS_C_GENERATOR 1
`define ISS_S_ALIGN_LOSS 0
`define ISS_S_ALIGN_DONE 1
`define ISS_SUB_MASK 2'h3

// Status byte summary bit positions
`define ISS_STB_QUES 3
`define ISS_STB_OPER 7

`endif

// ### design/iss_reg_group.v
// Status register group: condition, transition latch, enable and summary
`timescale 1ns/10ps
`default_nettype none

module iss_reg_group #(
  parameter W = 16,
  parameter [W-1:0] MASK = {W{1'b1}}
) (
  input wire clk_sys, // System clock
  input wire nrst, // Asynchronous reset, active low
  input wire [W-1:0] cond_in, // Live condition levels
  input wire ena_wr, // Enable register write strobe
  input wire [W-1:0] ena_wdata, // Enable register write data
  input wire evt_clr, // Clear latched events on read
  output reg [W-1:0] cond, // Registered condition
  output reg [W-1:0] evt, // Latched rising transitions
  output reg [W-1:0] ena, // Summary enable mask
  output reg summary // OR of enabled latched events
);

  wire [W-1:0] rise;

  // Rising transitions of implemented bits only
  assign rise = cond_in & ~cond & MASK;

  // Condition capture, unused bits held at zero
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cond <= {W{1'b0}};
    end else begin
      cond <= cond_in & MASK;
    end
  end

  // Event latch, a new set wins over a read clear
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      evt <= {W{1'b0}};
    end else if (evt_clr) begin
      evt <= rise;
    end else begin
      evt <= evt | rise;
    end
  end

  // Enable mask, unused bits ignore writes
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ena <= MASK;
    end else if (ena_wr) begin
      ena <= ena_wdata & MASK;
    end
  end

  // Summary follows one cycle after events or enables change
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      summary <= 1'b0;
    end else begin
      summary <= |(evt & ena);
    end
  end

endmodule

`default_nettype wire

// ### design/iss_status_summary.v
// Top of the instrument status summary block
`timescale 1ns/10ps
`default_nettype none
`include "iss_consts.vh"

module iss_status_summary #(
  parameter W = 16
) (
  // Clock and reset
  input wire clk_sys, // System clock, 100 MHz
  input wire nrst, // Asynchronous reset, active low
  // Questionable condition inputs
  input wire source_absent, // Data source off, missing or faulty
  input wire threshold_outside_eye, // Decision threshold outside eye
  input wire receiver_side_clock_loss, // Receiver has no clock input
  input wire generator_side_clock_loss, // Generator has no external clock
  input wire input_guard_trip, // Receiver data input protection tripped
  input wire delay_input_guard_trip, // Generator delay input protection tripped
  input wire calibration_mismatch, // Module serial differs from calibration
  input wire pattern_mismatch, // Expected pattern differs from data
  input wire ratio_over_sync_limit, // Error ratio above sync threshold
  input wire symbol_align_lost, // Ten-bit symbol alignment lost
  input wire symbol_align_done, // Ten-bit symbol alignment completed
  // Operation condition inputs
  input wire temperature_high, // A module runs above normal temperature
  input wire gate_running, // Accumulated gated measurement running
  input wire gate_aborted, // Accumulation period aborted, pulse
  input wire bit_error_seen, // Receiver saw a bit error, pulse
  input wire sampling_point_centering, // Clock to data centering running
  input wire threshold_align_running, // Threshold alignment running
  input wire auto_align_running, // Automatic alignment running
  input wire fault_position_capture, // Error position capture running
  input wire block_change, // Sequence passed to next block, pulse
  // Register command port
  input wire reg_rd, // Register read strobe
  input wire reg_wr, // Register write strobe
  input wire [`ISS_SEL_W-1:0] reg_sel, // Register select code
  input wire [W-1:0] reg_wdata, // Register write data
  output reg [W-1:0] reg_rdata, // Register read data
  output reg reg_ack, // Access answered, pulse
  output reg reg_err, // Access refused, pulse
  // Summary outputs
  output reg [7:0] status_byte, // Summary bits of the status byte
  output wire ques_summary, // Questionable register summary
  output wire oper_summary // Operation register summary
);

  // Questionable group wiring
  wire [W-1:0] ques_in;
  wire [W-1:0] ques_cond;
  wire [W-1:0] ques_evt;
  wire [W-1:0] ques_ena;
  // Operation group wiring
  wire [W-1:0] oper_in;
  wire [W-1:0] oper_cond;
  wire [W-1:0] oper_evt;
  wire [W-1:0] oper_ena;
  // Clock-loss sub-register wiring
  wire [`ISS_SUB_W-1:0] clk_in;
  wire [`ISS_SUB_W-1:0] clk_cond;
  wire [`ISS_SUB_W-1:0] clk_evt;
  wire [`ISS_SUB_W-1:0] clk_ena;
  // Symbol-alignment sub-register wiring
  wire [`ISS_SUB_W-1:0] sym_in;
  wire [`ISS_SUB_W-1:0] sym_cond;
  wire [`ISS_SUB_W-1:0] sym_evt;
  wire [`ISS_SUB_W-1:0] sym_ena;
  wire sym_summary;
  // Access decode
  wire rd_ok;
  wire wr_ok;
  reg [W-1:0] next_rdata;
  // Per-register strobes from the access decode
  wire ques_ena_wr;
  wire oper_ena_wr;
  wire clk_ena_wr;
  wire sym_ena_wr;
  wire ques_evt_rd;
  wire oper_evt_rd;
  wire clk_evt_rd;
  wire sym_evt_rd;

  // True when the select code names a mapped register
  function sel_mapped;
    input [`ISS_SEL_W-1:0] sel;
    begin
      sel_mapped = (sel <= `ISS_SEL_STB);
    end
  endfunction

  // True when the select code names a writable enable register
  function sel_writable;
    input [`ISS_SEL_W-1:0] sel;
    begin
      sel_writable = (sel == `ISS_SEL_QUES_ENA) || (sel == `ISS_SEL_OPER_ENA) ||
                     (sel == `ISS_SEL_CLK_ENA) || (sel == `ISS_SEL_SYM_ENA);
    end
  endfunction

  // Read takes priority when both strobes arrive together
  assign rd_ok = reg_rd && sel_mapped(reg_sel);
  // A write that loses to a read is dropped, not refused
  assign wr_ok = reg_wr && !reg_rd && sel_writable(reg_sel);

  // Enable writes, one strobe per group
  assign ques_ena_wr = wr_ok && (reg_sel == `ISS_SEL_QUES_ENA);
  assign oper_ena_wr = wr_ok && (reg_sel == `ISS_SEL_OPER_ENA);
  assign clk_ena_wr = wr_ok && (reg_sel == `ISS_SEL_CLK_ENA);
  assign sym_ena_wr = wr_ok && (reg_sel == `ISS_SEL_SYM_ENA);

  // Event reads clear the latched bits they return
  assign ques_evt_rd = rd_ok && (reg_sel == `ISS_SEL_QUES_EVT);
  assign oper_evt_rd = rd_ok && (reg_sel == `ISS_SEL_OPER_EVT);
  assign clk_evt_rd = rd_ok && (reg_sel == `ISS_SEL_CLK_EVT);
  assign sym_evt_rd = rd_ok && (reg_sel == `ISS_SEL_SYM_EVT);

  // Clock-loss causes, receiver low and generator high
  assign clk_in[`ISS_C_RECEIVER] = receiver_side_clock_loss;
  assign clk_in[`ISS_C_GENERATOR] = generator_side_clock_loss;

  // Symbol alignment outcomes, loss low and done high
  assign sym_in[`ISS_S_ALIGN_LOSS] = symbol_align_lost;
  assign sym_in[`ISS_S_ALIGN_DONE] = symbol_align_done;

  // Questionable conditions; unused bits stay zero
  assign ques_in[`ISS_Q_DATA_LOSS] = source_absent | threshold_outside_eye;
  assign ques_in[4:1] = 4'h0;
  assign ques_in[`ISS_Q_CLOCK_LOSS] = |clk_cond;
  assign ques_in[`ISS_Q_INPUT_GUARD] = input_guard_trip;
  assign ques_in[`ISS_Q_DELAY_GUARD] = delay_input_guard_trip;
  assign ques_in[`ISS_Q_CAL_MISMATCH] = calibration_mismatch;
  assign ques_in[9] = 1'b0;
  assign ques_in[`ISS_Q_SYNC_LOSS] = pattern_mismatch | ratio_over_sync_limit;
  // Bit 11 has no source in this block
  assign ques_in[11] = 1'b0;
  assign ques_in[`ISS_Q_SYMBOL] = sym_summary;
  assign ques_in[15:13] = 3'h0;

  // Operation conditions; unused bits stay zero
  assign oper_in[2:0] = 3'h0;
  assign oper_in[`ISS_O_TEMP_HIGH] = temperature_high;
  assign oper_in[`ISS_O_GATE_ON] = gate_running;
  assign oper_in[6:5] = 2'h0;
  assign oper_in[`ISS_O_GATE_ABORT] = gate_aborted;
  assign oper_in[`ISS_O_BIT_ERR] = bit_error_seen;
  assign oper_in[10:9] = 2'h0;
  assign oper_in[`ISS_O_CENTERING] = sampling_point_centering;
  assign oper_in[`ISS_O_THR_ALIGN] = threshold_align_running;
  assign oper_in[`ISS_O_AUTO_ALIGN] = auto_align_running;
  assign oper_in[`ISS_O_FAULT_CAPTURE] = fault_position_capture;
  assign oper_in[`ISS_O_BLOCK_CHANGE] = block_change;

  // Clock-loss sub-register group
  iss_reg_group #(
    .W(`ISS_SUB_W),
    .MASK(`ISS_SUB_MASK)
  ) u_clk (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .cond_in(clk_in),
    .ena_wr(clk_ena_wr),
    .ena_wdata(reg_wdata[`ISS_SUB_W-1:0]),
    .evt_clr(clk_evt_rd),
    .cond(clk_cond),
    .evt(clk_evt),
    .ena(clk_ena),
    .summary()
  );

  // Symbol-alignment sub-register group
  iss_reg_group #(
    .W(`ISS_SUB_W),
    .MASK(`ISS_SUB_MASK)
  ) u_sym (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .cond_in(sym_in),
    .ena_wr(sym_ena_wr),
    .ena_wdata(reg_wdata[`ISS_SUB_W-1:0]),
    .evt_clr(sym_evt_rd),
    .cond(sym_cond),
    .evt(sym_evt),
    .ena(sym_ena),
    .summary(sym_summary)
  );

  // Questionable register group
  iss_reg_group #(
    .W(W),
    .MASK(`ISS_Q_MASK)
  ) u_ques (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .cond_in(ques_in),
    .ena_wr(ques_ena_wr),
    .ena_wdata(reg_wdata),
    .evt_clr(ques_evt_rd),
    .cond(ques_cond),
    .evt(ques_evt),
    .ena(ques_ena),
    .summary(ques_summary)
  );

  // Operation register group
  iss_reg_group #(
    .W(W),
    .MASK(`ISS_O_MASK)
  ) u_oper (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .cond_in(oper_in),
    .ena_wr(oper_ena_wr),
    .ena_wdata(reg_wdata),
    .evt_clr(oper_evt_rd),
    .cond(oper_cond),
    .evt(oper_evt),
    .ena(oper_ena),
    .summary(oper_summary)
  );

  // Read data selection, values before any read clear
  always @* begin
    next_rdata = {W{1'b0}};
    case (reg_sel)
      `ISS_SEL_QUES_COND: next_rdata = ques_cond;
      `ISS_SEL_QUES_EVT: next_rdata = ques_evt;
      `ISS_SEL_QUES_ENA: next_rdata = ques_ena;
      `ISS_SEL_OPER_COND: next_rdata = oper_cond;
      `ISS_SEL_OPER_EVT: next_rdata = oper_evt;
      `ISS_SEL_OPER_ENA: next_rdata = oper_ena;
      `ISS_SEL_CLK_COND: next_rdata = {{(W-`ISS_SUB_W){1'b0}}, clk_cond};
      `ISS_SEL_CLK_EVT: next_rdata = {{(W-`ISS_SUB_W){1'b0}}, clk_evt};
      `ISS_SEL_CLK_ENA: next_rdata = {{(W-`ISS_SUB_W){1'b0}}, clk_ena};
      `ISS_SEL_SYM_COND: next_rdata = {{(W-`ISS_SUB_W){1'b0}}, sym_cond};
      `ISS_SEL_SYM_EVT: next_rdata = {{(W-`ISS_SUB_W){1'b0}}, sym_evt};
      `ISS_SEL_SYM_ENA: next_rdata = {{(W-`ISS_SUB_W){1'b0}}, sym_ena};
      `ISS_SEL_STB: next_rdata = {{(W-8){1'b0}}, status_byte};
      default: next_rdata = {W{1'b0}};
    endcase
  end

  // Read data register, held until the next read
  // A refused read loads zero, never stale data
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= {W{1'b0}};
    end else if (rd_ok) begin
      reg_rdata <= next_rdata;
    end else if (reg_rd) begin
      reg_rdata <= {W{1'b0}};
    end
  end

  // Acknowledge, one cycle after an accepted strobe
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= rd_ok | wr_ok;
    end
  end

  // Refusal, one cycle after a read of an unmapped select or a write to a non-enable select
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_err <= 1'b0;
    end else begin
      reg_err <= (reg_rd & ~rd_ok) | (reg_wr & ~reg_rd & ~wr_ok);
    end
  end

  // Status byte summary bits, owned bits only
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_byte <= 8'h00;
    end else begin
      status_byte <= 8'h00;
      status_byte[`ISS_STB_QUES] <= ques_summary;
      status_byte[`ISS_STB_OPER] <= oper_summary;
    end
  end

endmodule

`default_nettype wire

// ### sim/iss_status_summary_sva.sv
// Port checker for the status summary block
`timescale 1ns/10ps
`default_nettype none
module iss_status_summary_sva (
  input wire clk_sys, // Clock
  input wire nrst, // Reset, active low
  input wire temperature_high, // Oper input
  input wire gate_running, // Oper input
  input wire block_change, // Oper input
  input wire reg_rd, // Read strobe
  input wire reg_wr, // Write strobe
  input wire [3:0] reg_sel, // Select code
  input wire [15:0] reg_rdata, // Read data
  input wire reg_ack, // Answer
  input wire reg_err, // Refusal
  input wire [7:0] status_byte, // Status byte
  input wire ques_summary, // Ques summary
  input wire oper_summary // Oper summary
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Levels that must reach the oper summary
  wire [2:0] oper_vec = {temperature_high, gate_running, block_change};
  a_stb_ques_bit: assert property (status_byte[3] == $past(ques_summary)) else $error("bad ques bit");
  a_stb_oper_bit: assert property (status_byte[7] == $past(oper_summary)) else $error("bad oper bit");
  a_stb_rest_zero: assert property ((status_byte & 8'h77) == 8'h00) else $error("stray status bit");
  a_oper_rise_sum: assert property (|(oper_vec & ~$past(oper_vec)) |-> ##2 oper_summary)
    else $error("oper summary missing");
  a_req_gets_answer: assert property ((reg_rd || reg_wr) |=> (reg_ack ^ reg_err)) else $error("no answer");
  a_answer_has_cause: assert property ((reg_ack || reg_err) |-> $past(reg_rd || reg_wr)) else $error("stray answer");
  a_bad_sel_err: assert property (reg_rd && reg_sel > 4'hC |=> reg_err && reg_rdata == 16'h0000)
    else $error("bad select not refused");
  a_ro_write_err: assert property (reg_wr && !reg_rd && reg_sel != 4'h2 && reg_sel != 4'h5
    && reg_sel != 4'h8 && reg_sel != 4'hB |=> reg_err) else $error("read-only write accepted");
  a_ques_ena_mask: assert property (reg_rd && reg_sel == 4'h2 |=> (reg_rdata & 16'hEA1E) == 16'h0)
    else $error("unused ques bit set");
  a_oper_ena_mask: assert property (reg_rd && reg_sel == 4'h5 |=> (reg_rdata & 16'h0667) == 16'h0)
    else $error("unused oper bit set");
endmodule
bind iss_status_summary iss_status_summary_sva iss_status_summary_sva_i (.clk_sys(clk_sys), .nrst(nrst),
  .temperature_high(temperature_high), .gate_running(gate_running), .block_change(block_change),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .reg_err(reg_err), .status_byte(status_byte), .ques_summary(ques_summary), .oper_summary(oper_summary));
`default_nettype wire

// ### sim/iss_status_summary_tb_top.sv
// Self-checking bench for the status summary block
`timescale 1ns/10ps
`default_nettype none
module iss_status_summary_tb_top;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [19:0] stim = 20'h0;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [3:0] reg_sel = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  wire [15:0] reg_rdata;
  wire reg_ack;
  wire reg_err;
  wire [7:0] status_byte;
  wire ques_summary;
  wire oper_summary;
  int n_mismatch = 0;
  int n_checks = 0;
  // Clock at 100 MHz
  always #5 clk_sys = ~clk_sys;
  iss_status_summary iss_status_summary_i (.clk_sys(clk_sys), .nrst(nrst), .source_absent(stim[0]),
    .threshold_outside_eye(stim[1]), .receiver_side_clock_loss(stim[2]), .generator_side_clock_loss(stim[3]),
    .input_guard_trip(stim[4]), .delay_input_guard_trip(stim[5]), .calibration_mismatch(stim[6]),
    .pattern_mismatch(stim[7]), .ratio_over_sync_limit(stim[8]), .symbol_align_lost(stim[9]),
    .symbol_align_done(stim[10]), .temperature_high(stim[11]), .gate_running(stim[12]), .gate_aborted(stim[13]),
    .bit_error_seen(stim[14]), .sampling_point_centering(stim[15]), .threshold_align_running(stim[16]),
    .auto_align_running(stim[17]), .fault_position_capture(stim[18]), .block_change(stim[19]),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .status_byte(status_byte), .ques_summary(ques_summary),
    .oper_summary(oper_summary));
  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One register access, answer one cycle after the strobe edge
  task automatic acc(input logic wr, input logic [3:0] sel, input logic [15:0] wd, input logic bad,
                     input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd <= ~wr;
    reg_wr <= wr;
    reg_sel <= sel;
    reg_wdata <= wd;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    #1;
    chk("reg_err", {15'h0, reg_err}, {15'h0, bad});
    chk("reg_ack", {15'h0, reg_ack}, {15'h0, ~bad});
    if (!wr) chk("reg_rdata", reg_rdata, exp);
  endtask
  // Raise one input, see condition, event, summaries, then clear
  task automatic test_in(input int idx, input logic op, input int b, input logic [3:0] sub, input int sb);
    logic [15:0] m;
    m = 16'h1 << b;
    @(posedge clk_sys);
    stim[idx] <= 1'b1;
    repeat (5) @(posedge clk_sys);
    acc(1'b0, op ? 4'h3 : 4'h0, 16'h0, 1'b0, m);
    #1;
    chk("summary", {14'h0, oper_summary, ques_summary}, op ? 16'h2 : 16'h1);
    chk("status_byte", {8'h0, status_byte}, op ? 16'h80 : 16'h08);
    if (sub != 4'h0) acc(1'b0, sub, 16'h0, 1'b0, 16'h1 << sb);
    @(posedge clk_sys);
    stim[idx] <= 1'b0;
    repeat (5) @(posedge clk_sys);
    if (sub != 4'h0) acc(1'b0, sub + 4'h1, 16'h0, 1'b0, 16'h1 << sb);
    acc(1'b0, op ? 4'h4 : 4'h1, 16'h0, 1'b0, m);
    acc(1'b0, op ? 4'h4 : 4'h1, 16'h0, 1'b0, 16'h0);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("summary idle", {14'h0, oper_summary, ques_summary}, 16'h0);
    chk("status_byte idle", {8'h0, status_byte}, 16'h0);
    acc(1'b0, op ? 4'h3 : 4'h0, 16'h0, 1'b0, 16'h0);
    $display("test input %0d done", idx);
  endtask
  // Print counts and verdict, end the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
  // Test sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    acc(1'b0, 4'h2, 16'h0, 1'b0, 16'h15E1);
    acc(1'b0, 4'h5, 16'h0, 1'b0, 16'hF998);
    acc(1'b0, 4'h8, 16'h0, 1'b0, 16'h0003);
    acc(1'b0, 4'hB, 16'h0, 1'b0, 16'h0003);
    acc(1'b0, 4'hC, 16'h0, 1'b0, 16'h0000);
    acc(1'b1, 4'h5, 16'hFFFF, 1'b0, 16'h0);
    acc(1'b0, 4'h5, 16'h0, 1'b0, 16'hF998);
    acc(1'b1, 4'h0, 16'hFFFF, 1'b1, 16'h0);
    acc(1'b0, 4'h0, 16'h0, 1'b0, 16'h0000);
    acc(1'b1, 4'h8, 16'h0000, 1'b0, 16'h0);
    acc(1'b0, 4'h8, 16'h0, 1'b0, 16'h0000);
    acc(1'b1, 4'h8, 16'hFFFF, 1'b0, 16'h0);
    acc(1'b0, 4'h8, 16'h0, 1'b0, 16'h0003);
    acc(1'b1, 4'hB, 16'hFFFF, 1'b0, 16'h0);
    acc(1'b0, 4'hB, 16'h0, 1'b0, 16'h0003);
    acc(1'b0, 4'hD, 16'h0, 1'b1, 16'h0000);
    // Read wins over a write in the same cycle
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_wr <= 1'b1;
    reg_sel <= 4'h5;
    reg_wdata <= 16'h0000;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    #1;
    chk("both answer", {14'h0, reg_err, reg_ack}, 16'h0001);
    chk("both rdata", reg_rdata, 16'hF998);
    acc(1'b0, 4'h5, 16'h0, 1'b0, 16'hF998);
    $display("test access done");
    test_in(0, 1'b0, 0, 4'h0, 0);
    test_in(1, 1'b0, 0, 4'h0, 0);
    test_in(2, 1'b0, 5, 4'h6, 0);
    test_in(3, 1'b0, 5, 4'h6, 1);
    test_in(4, 1'b0, 6, 4'h0, 0);
    test_in(5, 1'b0, 7, 4'h0, 0);
    test_in(6, 1'b0, 8, 4'h0, 0);
    test_in(7, 1'b0, 10, 4'h0, 0);
    test_in(8, 1'b0, 10, 4'h0, 0);
    test_in(9, 1'b0, 12, 4'h9, 0);
    test_in(10, 1'b0, 12, 4'h9, 1);
    test_in(11, 1'b1, 3, 4'h0, 0);
    test_in(12, 1'b1, 4, 4'h0, 0);
    test_in(13, 1'b1, 7, 4'h0, 0);
    test_in(14, 1'b1, 8, 4'h0, 0);
    test_in(15, 1'b1, 11, 4'h0, 0);
    test_in(16, 1'b1, 12, 4'h0, 0);
    test_in(17, 1'b1, 13, 4'h0, 0);
    test_in(18, 1'b1, 14, 4'h0, 0);
    test_in(19, 1'b1, 15, 4'h0, 0);
    // Masked event stays out of the summary until enabled
    acc(1'b1, 4'h2, 16'h0000, 1'b0, 16'h0);
    @(posedge clk_sys);
    stim[4] <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    chk("masked summary", {15'h0, ques_summary}, 16'h0);
    acc(1'b1, 4'h2, 16'h0040, 1'b0, 16'h0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("enabled summary", {15'h0, ques_summary}, 16'h1);
    @(posedge clk_sys);
    stim[4] <= 1'b0;
    acc(1'b0, 4'h1, 16'h0, 1'b0, 16'h0040);
    acc(1'b1, 4'h2, 16'hFFFF, 1'b0, 16'h0);
    acc(1'b0, 4'h2, 16'h0, 1'b0, 16'h15E1);
    $display("test enable mask done");
    stop_test();
  end
endmodule
`default_nettype wire
